// ---- hdl/wdc_watchdog.sv ----
// Windowed countdown watchdog: control register, prescaler, halt handling and reset pulse
//
// How it works
// R01 - Maximum timeout: 16384 periods per count, timebase substitution beyond quarter of constant.
// R02 - Halt without timebase irq or halt reset: decrement once, then freeze.
// R03 - External interrupt wakes plain halt; counting resumes after 256 or 4096 clocks.
// R04 - Reset ending halt returns control to reset state, with or without hardware option.
// R05 - Halt with halt reset option and timebase irq clear makes a chip reset.
// R06 - Halt with timebase irq set freezes counter; any interrupt restarts at once.
// R07 - Reset ending active halt resumes counting after 256 or 4096 clocks.
// R08 - Hardware option keeps the watchdog active and ignores the activation bit.
// R09 - Activation bit set by software, cleared only by reset, enables resets.
// R10 - Counter decrements every prescaler period; reset when it rolls 40h to 3Fh.
// R11 - Control register resets to 7Fh.
// R12 - Software should reload the counter before halting with the watchdog on.
// R13 - Firing drives the reset pin low for 500 ns.
// R14 - Writing activation set with top bit clear gives an immediate reset.
// R15 - Prescaler runs free, untouched by register writes.
// R16 - No interrupt output; only a reset request leaves the block.
`default_nettype none

`include "wdc_map.svh"

module wdc_watchdog #(
    parameter int PRESCALE = `WDC_PRESCALE,
    parameter int WAKE_SHORT = `WDC_WAKE_SHORT,
    parameter int WAKE_LONG = `WDC_WAKE_LONG
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire wdc_pkg::wdc_bus_req_t bus_req_in,
    output logic [7:0] reg_rdata_out,
    input wire logic hw_watchdog_opt_in,
    input wire logic halt_reset_option_in,
    input wire logic timebase_irq_enable_in,
    input wire logic [1:0] timebase_select_in,
    input wire logic halt_instr_in,
    input wire logic ext_irq_in,
    input wire logic osc_irq_in,
    input wire logic wake_reset_in,
    input wire logic wake_long_in,
    output logic chip_reset_n_out,
    output logic [4:0] wdg_state_out,
    output logic [23:0] timeout_max_out
);

    localparam int PULSE_CYCLES = `WDC_RESET_PULSE_CYCLES;
    // First delay cycle plus the timer's load and done flops
    localparam int WAKE_SHORT_WAIT = WAKE_SHORT + 1;

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;
    logic [13:0] presc_reg;
    logic tick;
    logic activation_bit_reg;
    logic [6:0] count_reg;
    wdc_pkg::wdc_state_t state_reg;
    wdc_pkg::wdc_state_t state_next;
    logic [5:0] pulse_cnt_reg;
    logic chip_reset_n_reg;
    logic [7:0] rdata_reg;
    logic [23:0] tmax_reg;
    logic enabled;
    logic ctrl_wr;
    logic fire;
    logic delay_start;
    logic delay_done;
    logic halt_plain;
    logic halt_to_reset;
    logic halt_active;

    // Reset release through two flops; only the second one is used
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // Free-running prescaler; writes never restart it, so first step is uncertain
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= 14'h0000;
        end else if (presc_reg == 14'(PRESCALE - 1)) begin
            presc_reg <= 14'h0000; // R15
        end else begin
            presc_reg <= presc_reg + 14'h0001; // R15
        end
    end
    assign tick = (presc_reg == 14'(PRESCALE - 1));

    // Decode and the conditions that drive the state machine
    assign enabled = activation_bit_reg | hw_watchdog_opt_in; // R08 R09
    assign ctrl_wr = bus_req_in.wr && (bus_req_in.addr == `WDC_CTRL_ADDR);
    assign halt_plain = (state_reg == wdc_pkg::WDC_RUN) && halt_instr_in && !timebase_irq_enable_in
        && !halt_reset_option_in; // R02
    assign halt_to_reset = (state_reg == wdc_pkg::WDC_RUN) && halt_instr_in && !timebase_irq_enable_in
        && halt_reset_option_in; // R05
    assign halt_active = (state_reg == wdc_pkg::WDC_RUN) && halt_instr_in && timebase_irq_enable_in; // R06

    // Reset request sources; a pulse already running absorbs new ones
    always_comb begin
        fire = 1'b0;
        if (!wake_reset_in && enabled) begin
            if ((state_reg == wdc_pkg::WDC_RUN) && tick && !ctrl_wr && (count_reg == `WDC_ROLL_VALUE)) begin
                fire = 1'b1; // R10
            end else if (halt_to_reset) begin
                fire = 1'b1; // R05
            end
        end
        if (ctrl_wr && !wake_reset_in && bus_req_in.wdata[`WDC_ACT_BIT] && !bus_req_in.wdata[`WDC_TOP_BIT]) begin
            fire = 1'b1; // R14
        end
    end

    // Operating state transitions
    always_comb begin
        state_next = state_reg;
        delay_start = 1'b0;
        case (state_reg)
            wdc_pkg::WDC_RUN: begin
                if (halt_plain) begin
                    state_next = wdc_pkg::WDC_HALTED; // R02
                end else if (halt_active) begin
                    state_next = wdc_pkg::WDC_ACTIVE_HALT; // R06
                end
            end
            wdc_pkg::WDC_HALTED: begin
                if (wake_reset_in) begin
                    state_next = wdc_pkg::WDC_RUN; // R04
                end else if (ext_irq_in) begin
                    state_next = wdc_pkg::WDC_WAKE_DELAY; // R03
                    delay_start = 1'b1;
                end
            end
            wdc_pkg::WDC_ACTIVE_HALT: begin
                if (wake_reset_in) begin
                    state_next = wdc_pkg::WDC_WAKE_DELAY; // R07
                    delay_start = 1'b1;
                end else if (osc_irq_in || ext_irq_in) begin
                    state_next = wdc_pkg::WDC_RUN; // R06
                end
            end
            wdc_pkg::WDC_WAKE_DELAY: begin
                if (delay_done) begin
                    state_next = wdc_pkg::WDC_RUN; // R03 R07
                end
            end
            default: begin
                state_next = wdc_pkg::WDC_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= wdc_pkg::WDC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Restart delay after a wake from halt or active halt
    wdc_delay_timer #(
        .SHORT_CYCLES(WAKE_SHORT),
        .LONG_CYCLES(WAKE_LONG)
    ) u_delay (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .start_in(delay_start),
        .long_in(wake_long_in),
        .done_out(delay_done)
    );

    // Activation bit: software can only set it, a reset clears it
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            activation_bit_reg <= 1'b0; // R11
        end else if (wake_reset_in && (state_reg != wdc_pkg::WDC_RUN)) begin
            activation_bit_reg <= 1'b0; // R04
        end else if (ctrl_wr && bus_req_in.wdata[`WDC_ACT_BIT]) begin
            activation_bit_reg <= 1'b1; // R09
        end
    end

    // Counter: a write wins over a prescaler step in the same cycle
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 7'(`WDC_CTRL_RESET); // R11
        end else if (wake_reset_in && (state_reg != wdc_pkg::WDC_RUN)) begin
            count_reg <= 7'(`WDC_CTRL_RESET); // R04
        end else if (ctrl_wr) begin
            count_reg <= bus_req_in.wdata[6:0];
        end else if (halt_plain) begin
            count_reg <= count_reg - 7'h01; // R02
        end else if ((state_reg == wdc_pkg::WDC_RUN) && tick) begin
            count_reg <= count_reg - 7'h01; // R10
        end
    end

    // Reset pulse toward the reset generator, the only outgoing request
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt_reg <= 6'h00;
            chip_reset_n_reg <= 1'b1;
        end else if (fire && (pulse_cnt_reg == 6'h00)) begin
            pulse_cnt_reg <= 6'(PULSE_CYCLES); // R13
            chip_reset_n_reg <= 1'b0; // R16
        end else if (pulse_cnt_reg != 6'h00) begin
            pulse_cnt_reg <= pulse_cnt_reg - 6'h01;
            chip_reset_n_reg <= (pulse_cnt_reg == 6'h01); // R13
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (bus_req_in.rd && (bus_req_in.addr == `WDC_CTRL_ADDR)) begin
            rdata_reg <= {activation_bit_reg, count_reg};
        end else begin
            rdata_reg <= `WDC_UNMAPPED_READ;
        end
    end

    // Maximum timeout for the loaded count; divisions truncate
    function automatic logic [23:0] max_timeout(input logic [5:0] cnt, input logic [1:0] tb);
        logic [7:0] msb;
        logic [7:0] lsb;
        logic [7:0] q;
        logic [23:0] t;
        msb = `WDC_TB0_MSB;
        lsb = `WDC_TB0_LSB;
        if (tb == 2'h1) begin
            msb = `WDC_TB1_MSB;
            lsb = `WDC_TB1_LSB;
        end else if (tb == 2'h2) begin
            msb = `WDC_TB2_MSB;
            lsb = `WDC_TB2_LSB;
        end else if (tb == 2'h3) begin
            msb = `WDC_TB3_MSB;
            lsb = `WDC_TB3_LSB;
        end
        q = {cnt, 2'b00} / msb;
        if ({2'b00, cnt} <= (msb >> 2)) begin
            t = 24'(`WDC_TMAX0) + 24'(24'(`WDC_TMAX_PER_COUNT) * {18'h0, cnt}); // R01
        end else begin
            t = 24'(`WDC_TMAX0) + 24'(24'(`WDC_TMAX_PER_COUNT) * {18'h0, 6'(cnt - q[5:0])})
                + 24'((24'(`WDC_TB_OFFSET) + {16'h0, lsb}) * 24'(`WDC_TB_STEP) * {16'h0, q}); // R01
        end
        return t;
    endfunction : max_timeout

    // Timeout figure kept in a flop so software-facing logic sees it cleanly
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tmax_reg <= 24'h000000;
        end else begin
            tmax_reg <= max_timeout(count_reg[5:0], timebase_select_in); // R01
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign chip_reset_n_out = chip_reset_n_reg;
    assign wdg_state_out = state_reg;
    assign timeout_max_out = tmax_reg;

    // Checks kept beside the logic they guard
    a_rollover_fires: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R10
        (state_reg == wdc_pkg::WDC_RUN) && tick && enabled && !ctrl_wr && !wake_reset_in
        && (count_reg == `WDC_ROLL_VALUE) && (pulse_cnt_reg == 6'h00) |=> !chip_reset_n_out)
        else $error("rollover did not start a reset pulse");

    a_pulse_width: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R13
        $fell(chip_reset_n_out) |-> !chip_reset_n_out [*8] ##42 !chip_reset_n_out ##1 chip_reset_n_out)
        else $error("reset pulse not fifty cycles long");

    a_soft_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R14
        ctrl_wr && !wake_reset_in && bus_req_in.wdata[7] && !bus_req_in.wdata[6] && (pulse_cnt_reg == 6'h00)
        |=> !chip_reset_n_out)
        else $error("software reset write ignored");

    a_halt_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R05
        halt_to_reset && enabled && !wake_reset_in && (pulse_cnt_reg == 6'h00)
        |=> !chip_reset_n_out && (state_reg == wdc_pkg::WDC_RUN))
        else $error("halt with reset option did not reset");

    a_halt_frozen: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R02
        (state_reg == wdc_pkg::WDC_HALTED) && !ctrl_wr && !wake_reset_in
        && (pulse_cnt_reg == 6'h00) |=> $stable(count_reg) && chip_reset_n_out)
        else $error("counter moved or reset during halt");

    a_active_resume: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R06
        (state_reg == wdc_pkg::WDC_ACTIVE_HALT) && !wake_reset_in && (osc_irq_in || ext_irq_in)
        |=> (state_reg == wdc_pkg::WDC_RUN))
        else $error("active halt did not resume at once");

    a_short_wake: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R03
        $rose(state_reg == wdc_pkg::WDC_WAKE_DELAY) && !$past(wake_long_in)
        |-> ##WAKE_SHORT_WAIT (state_reg == wdc_pkg::WDC_RUN))
        else $error("short wake delay wrong");

    a_act_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R09
        activation_bit_reg && !wake_reset_in |=> activation_bit_reg)
        else $error("activation bit cleared without reset");

    a_halt_reset_state: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R04
        wake_reset_in && (state_reg == wdc_pkg::WDC_HALTED)
        |=> (state_reg == wdc_pkg::WDC_RUN) && ({activation_bit_reg, count_reg} == `WDC_CTRL_RESET))
        else $error("reset from halt did not restore reset state");

endmodule : wdc_watchdog

`default_nettype wire

// ---- hdl/wdc_map.svh ----
// Register offsets, field positions, reset values and timing counts of the countdown watchdog
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH

// Control register
`define WDC_CTRL_ADDR 8'h2a
`define WDC_CTRL_RESET 8'h7f
`define WDC_ACT_BIT 7
`define WDC_TOP_BIT 6
`define WDC_ROLL_VALUE 7'h40
`define WDC_UNMAPPED_READ 8'h00

// Clock and time figures
`define WDC_CLK_PERIOD_NS 10
`define WDC_RESET_PULSE_NS 500
`define WDC_RESET_PULSE_CYCLES ((`WDC_RESET_PULSE_NS + `WDC_CLK_PERIOD_NS - 1) / `WDC_CLK_PERIOD_NS)

// Prescaler and wake delays in clock cycles
`define WDC_PRESCALE 16384
`define WDC_WAKE_SHORT 256
`define WDC_WAKE_LONG 4096

// Maximum timeout arithmetic, in oscillator periods
`define WDC_TMAX0 16384
`define WDC_TMAX_PER_COUNT 16384
`define WDC_TB_OFFSET 192
`define WDC_TB_STEP 64

// Timebase table, upper and lower constants per select value
`define WDC_TB0_MSB 8'd4
`define WDC_TB0_LSB 8'd59
`define WDC_TB1_MSB 8'd8
`define WDC_TB1_LSB 8'd53
`define WDC_TB2_MSB 8'd20
`define WDC_TB2_LSB 8'd35
`define WDC_TB3_MSB 8'd49
`define WDC_TB3_LSB 8'd54

`endif

// ---- hdl/wdc_pkg.sv ----
// Types shared by the countdown watchdog files
`default_nettype none

package wdc_pkg;

    // Register port request, one cycle per access
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdc_bus_req_t;

    // Operating state, one-hot
    typedef enum logic [4:0] {
        WDC_RUN = 5'b00001,
        WDC_HALTED = 5'b00010,
        WDC_ACTIVE_HALT = 5'b00100,
        WDC_WAKE_DELAY = 5'b01000,
        WDC_SPARE = 5'b10000
    } wdc_state_t;

endpackage : wdc_pkg

`default_nettype wire

// ---- hdl/wdc_delay_timer.sv ----
// Restart delay timer used before the watchdog counts again after a wake
`default_nettype none

`include "wdc_map.svh"

module wdc_delay_timer #(
    parameter int SHORT_CYCLES = `WDC_WAKE_SHORT,
    parameter int LONG_CYCLES = `WDC_WAKE_LONG
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic long_in,
    output logic done_out
);

    logic [12:0] cnt_reg;
    logic done_reg;

    // Load on start, count down, one-cycle done when the count expires
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 13'h0000;
            done_reg <= 1'b0;
        end else if (start_in) begin
            cnt_reg <= long_in ? 13'(LONG_CYCLES) : 13'(SHORT_CYCLES);
            done_reg <= 1'b0;
        end else if (cnt_reg == 13'h0001) begin
            cnt_reg <= 13'h0000;
            done_reg <= 1'b1;
        end else if (cnt_reg != 13'h0000) begin
            cnt_reg <= cnt_reg - 13'h0001;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
        end
    end

    assign done_out = done_reg;

endmodule : wdc_delay_timer

`default_nettype wire

// ---- bench/windowed_countdown_watchdog_tb.sv ----
// Self-checking bench for the countdown watchdog: register port, firing, halt modes, timeout figure
`default_nettype none

module windowed_countdown_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Short counts keep the run brief; the wait and wake-delay expectations derive from these
    localparam int P = 16;
    localparam int WS = 8;
    localparam int WL = 16;
    localparam int HALT = 0;
    localparam int EXT = 1;
    localparam int OSC = 2;
    localparam int WRST = 3;

    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    wdc_pkg::wdc_bus_req_t req = '0;
    logic hw = 1'b0;
    logic opt = 1'b0;
    logic ie = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [3:0] ev = 4'h0;
    logic wake_long = 1'b0;
    logic [7:0] rdata;
    logic chip_reset_n;
    logic [4:0] state;
    logic [23:0] tmax_seen;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int msb_t [4] = '{4, 8, 20, 49};
    int lsb_t [4] = '{59, 53, 35, 54};
    logic [7:0] d;
    logic [7:0] d1;
    int n;

    wdc_watchdog #(.PRESCALE(P), .WAKE_SHORT(WS), .WAKE_LONG(WL)) dut (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .bus_req_in(req),
        .reg_rdata_out(rdata),
        .hw_watchdog_opt_in(hw),
        .halt_reset_option_in(opt),
        .timebase_irq_enable_in(ie),
        .timebase_select_in(sel),
        .halt_instr_in(ev[HALT]),
        .ext_irq_in(ev[EXT]),
        .osc_irq_in(ev[OSC]),
        .wake_reset_in(ev[WRST]),
        .wake_long_in(wake_long),
        .chip_reset_n_out(chip_reset_n),
        .wdg_state_out(state),
        .timeout_max_out(tmax_seen)
    );

    always #5 sys_clk_in = ~sys_clk_in;

    // Hang guard: far above the several hundred cycles the sequence needs
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Strap inputs idle before reset so nothing fires on release
    task automatic hard_reset;
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        hw <= 1'b0;
        opt <= 1'b0;
        ie <= 1'b0;
        repeat (5) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
    endtask : hard_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        req <= '0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        req <= '0;
        #1;
        v = rdata;
    endtask : rd

    task automatic pulse(input int i);
        @(posedge sys_clk_in);
        ev[i] <= 1'b1;
        @(posedge sys_clk_in);
        ev <= 4'h0;
        #1;
    endtask : pulse

    // Waits a bounded time for the reset request, then measures its length
    task automatic pulse_len(input int bound);
        int w;
        int lo;
        w = 0;
        lo = 0;
        #1;
        while (chip_reset_n !== 1'b0 && w < bound) begin
            @(posedge sys_clk_in);
            #1;
            w++;
        end
        while (chip_reset_n === 1'b0 && lo < 200) begin
            @(posedge sys_clk_in);
            #1;
            lo++;
        end
        check(lo, 50);
    endtask : pulse_len

    task automatic stays_high(input int cyc);
        int lo;
        lo = 0;
        repeat (cyc) begin
            @(posedge sys_clk_in);
            #1;
            lo += int'(chip_reset_n !== 1'b1);
        end
        check(lo, 0);
    endtask : stays_high

    task automatic wait_run(output int cnt);
        cnt = 0;
        while (state !== wdc_pkg::WDC_RUN && cnt < 100) begin
            @(posedge sys_clk_in);
            #1;
            cnt++;
        end
    endtask : wait_run

    function automatic int tmax(input int cnt, input int msb, input int lsb);
        int q;
        q = 4 * cnt / msb;
        if (cnt <= msb / 4) begin
            return 16384 + 16384 * cnt;
        end
        return 16384 + 16384 * (cnt - q) + (192 + lsb) * 64 * q;
    endfunction : tmax

    // Count is frozen while halted, so every select can be compared
    task automatic tmax_all(input logic [7:0] v);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_in);
            sel <= i[1:0];
            repeat (2) @(posedge sys_clk_in);
            #1;
            check(tmax_seen, tmax(int'(v[5:0]), msb_t[i], lsb_t[i]));
        end
    endtask : tmax_all

    initial begin
        hard_reset();
        rd(8'h2a, d);
        check(d, 8'h7f);
        rd(8'h10, d);
        check(d, 8'h00);
        wr(8'h10, 8'hc0);
        rd(8'h2a, d);
        check(d[7], 1'b0);
        // Disabled: the roll past 40h must stay silent
        wr(8'h2a, 8'h41);
        stays_high(4 * P);
        hw <= 1'b1;
        wr(8'h2a, 8'h41);
        pulse_len(3 * P + 4);
        hard_reset();
        wr(8'h2a, 8'hc1);
        pulse_len(3 * P + 4);
        hard_reset();
        wr(8'h2a, 8'hff);
        wr(8'h2a, 8'h7f);
        rd(8'h2a, d);
        check(d[7], 1'b1);
        wr(8'h2a, 8'h80);
        pulse_len(3);
        hard_reset();
        // Plain halt, short then long wake delay
        for (int k = 0; k < 2; k++) begin
            wr(8'h2a, 8'hff);
            pulse(HALT);
            check(state, wdc_pkg::WDC_HALTED);
            rd(8'h2a, d);
            check((d === 8'hfe) | (d === 8'hfd), 1'b1);
            repeat (4 * P) @(posedge sys_clk_in);
            rd(8'h2a, d1);
            check(d1, d);
            if (k == 0) begin
                tmax_all(d);
            end
            wake_long <= k[0];
            pulse(EXT);
            check(state, wdc_pkg::WDC_WAKE_DELAY);
            wait_run(n);
            check(n, (k == 0 ? WS : WL) + 1);
        end
        pulse(HALT);
        pulse(WRST);
        check(state, wdc_pkg::WDC_RUN);
        rd(8'h2a, d);
        check(d, 8'h7f);
        // Active halt: frozen, immediate restart, delayed restart after reset
        ie <= 1'b1;
        wr(8'h2a, 8'hc3);
        pulse(HALT);
        check(state, wdc_pkg::WDC_ACTIVE_HALT);
        rd(8'h2a, d);
        tmax_all(d);
        repeat (4 * P) @(posedge sys_clk_in);
        rd(8'h2a, d1);
        check(d1, d);
        pulse(OSC);
        check(state, wdc_pkg::WDC_RUN);
        pulse(HALT);
        pulse(EXT);
        check(state, wdc_pkg::WDC_RUN);
        pulse(HALT);
        wake_long <= 1'b0;
        pulse(WRST);
        check(state, wdc_pkg::WDC_WAKE_DELAY);
        wait_run(n);
        check(n, WS + 1);
        rd(8'h2a, d);
        check(d, 8'h7f);
        // Halt with the halt-reset option while enabled
        ie <= 1'b0;
        opt <= 1'b1;
        wr(8'h2a, 8'hff);
        pulse(HALT);
        pulse_len(2);
        hard_reset();
        final_report();
    end

endmodule : windowed_countdown_watchdog_tb

`default_nettype wire
